// ===== src/pdrd_pkg.sv
// shared constants and types of the parallel reference decoder
package pdrd_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_UNIT = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h8;
   localparam logic [3:0] OFF_REF = 4'hc;
   // control field positions
   localparam int CTRL_FMT_LSB = 0;
   localparam int CTRL_CARD16_BIT = 3;
   localparam int CTRL_WIDTH16_BIT = 4;
   // status field positions
   localparam int STAT_VALID_BIT = 0;
   localparam int STAT_RANGE_BIT = 1;
   localparam int STAT_FMTREJ_BIT = 2;
   localparam int STAT_FULL_BIT = 3;
   localparam int STAT_UNIT_LSB = 4;
   localparam int STAT_DEC_LSB = 7;
   // reset values
   localparam logic [2:0] FMT_RST = 3'h0;
   localparam logic [15:0] UNIT_RST = 16'h0000;
   // format codes and limits
   localparam logic [2:0] FMT_BCD5 = 3'h6;
   localparam logic [2:0] FMT_BIN = 3'h7;
   localparam logic [16:0] MAX_BCD5 = 17'd39998;
   localparam logic [16:0] FULL_BIN8 = 17'd255;
   localparam logic [16:0] FULL_BIN12 = 17'd4095;
   localparam logic [16:0] FULL_BIN16 = 17'd30000;
   localparam logic [16:0] MAX_BIN16 = 17'd33000;
   localparam logic [16:0] MAX_RPM3 = 17'd1599;
   localparam logic [16:0] MAX_RPM4 = 17'd15999;
   localparam logic [16:0] MAX_USER12 = 17'd4095;
   localparam logic [16:0] MAX_USER16 = 17'd10999;
   localparam logic [16:0] MAX_USERX = 17'd11000;
   localparam logic [15:0] UNIT_RPM_MIN = 16'd2;
   localparam logic [15:0] UNIT_USER_MIN = 16'd40;
   localparam logic [15:0] UNIT_DEC_STEP = 16'd10000;

   typedef enum logic [2:0] {U_HZ, U_PCT, U_RPM, U_USER, U_BIN} pdrd_unit_t;

   typedef struct packed {
      logic [2:0] fmt;
      logic card16;
      logic width16;
      logic [15:0] dispUnit;
   } pdrd_cfg_t;

   typedef struct packed {
      logic signed [31:0] value;
      pdrd_unit_t unit;
      logic [1:0] decimals;
      logic full;
   } pdrd_ref_t;
endpackage

// ===== src/pdrd_decoder.sv
// parallel digital reference decoder with avalon-mm register slave
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module pdrd_decoder import pdrd_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [15:0] refData,
   input wire logic refSign,
   input wire logic refStrobe,
   output pdrd_ref_t refOut,
   output logic refValid
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   pdrd_cfg_t cfg_q, cfg_d;
   pdrd_ref_t ref_q, ref_d;
   logic valid_q, valid_d, rangeErr_q, rangeErr_d, fmtRej_q, fmtRej_d;
   logic strobePrev_q, wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic capture;
   // decode results
   logic [3:0] dg0, dg1, dg2, dg3;
   logic [16:0] mag, limit, fullMag;
   logic [6:0] mult;
   logic neg, ok, full, bcdMode;
   pdrd_unit_t unit;
   logic [1:0] decs;
   logic signed [31:0] scaled;

   assign capture = refStrobe && !strobePrev_q;

   // ----------------------------------------
   // decode of the terminal word
   // ----------------------------------------
   always_comb begin
      dg0 = refData[3:0];
      dg1 = refData[7:4];
      dg2 = refData[11:8];
      dg3 = refData[15:12];
      mag = 17'd0;
      limit = 17'd0;
      fullMag = 17'd0;
      mult = 7'd1;
      neg = refSign;
      ok = 1'b1;
      full = 1'b0;
      unit = U_HZ;
      decs = 2'd0;
      bcdMode = (cfg_q.dispUnit >= UNIT_RPM_MIN) || (cfg_q.fmt < FMT_BCD5);
      if (!cfg_q.card16) begin
         if (cfg_q.fmt == FMT_BCD5 && !bcdMode) begin
            ok = 1'b0;
         end else if (!bcdMode) begin
            mag = {9'd0, refData[7:0]};
            limit = FULL_BIN8;
            fullMag = FULL_BIN8;
            unit = U_BIN;
            full = &refData[7:0];
         end else begin
            ok = (dg0 <= 4'd9);
            mag = 17'(dg0) + 17'(dg1) * 17'd10;
            limit = (cfg_q.fmt == 3'd0) ? 17'd110 : 17'd159;
         end
      end else if (!bcdMode && cfg_q.fmt == FMT_BIN) begin
         if (cfg_q.width16) begin
            mag = {1'b0, refData};
            limit = MAX_BIN16;
            fullMag = FULL_BIN16;
            full = &refData;
         end else begin
            mag = {5'd0, refData[11:0]};
            limit = FULL_BIN12;
            fullMag = FULL_BIN12;
            full = &refData[11:0];
         end
         unit = U_BIN;
      end else if (!bcdMode) begin
         neg = 1'b0;
         mag = 17'({refData[2:0], 1'b0}) + 17'(refData[6:3]) * 17'd10 + 17'(refData[10:7]) * 17'd100
            + 17'(refData[14:11]) * 17'd1000 + 17'({refSign, refData[15]}) * 17'd10000;
         ok = (refData[6:3] <= 4'd9) && (refData[10:7] <= 4'd9) && (refData[14:11] <= 4'd9)
            && ({refData[2:0], 1'b0} <= 4'd9);
         limit = MAX_BCD5;
         fullMag = MAX_BCD5;
         full = &{refSign, refData};
      end else begin
         ok = (dg0 <= 4'd9) && (dg1 <= 4'd9) && (dg2 <= 4'd9) && (!cfg_q.width16 || dg3 <= 4'd9);
         mag = 17'(dg0) + 17'(dg1) * 17'd10 + 17'(dg2) * 17'd100;
         if (cfg_q.width16) begin
            mag = mag + 17'(dg3) * 17'd1000;
         end
         unit = U_HZ;
      end
      if (full) begin
         mag = fullMag;
         ok = 1'b1;
      end
      if (cfg_q.card16 && bcdMode) begin
         if (cfg_q.dispUnit >= UNIT_USER_MIN) begin
            unit = U_USER;
            decs = 2'(cfg_q.dispUnit / UNIT_DEC_STEP);
            limit = cfg_q.width16 ? MAX_USER16 : MAX_USER12;
            if (cfg_q.dispUnit % UNIT_DEC_STEP == 16'd0) begin
               limit = MAX_USERX;
            end
         end else if (cfg_q.dispUnit >= UNIT_RPM_MIN) begin
            unit = U_RPM;
            limit = cfg_q.width16 ? MAX_RPM4 : MAX_RPM3;
         end else begin
            unique case (cfg_q.fmt)
               3'd0: limit = 17'd110;
               3'd1: limit = 17'd1100;
               3'd2: limit = cfg_q.width16 ? 17'd11000 : 17'd1599;
               3'd3: limit = 17'd400;
               3'd4: limit = cfg_q.width16 ? 17'd4000 : 17'd1599;
               default: limit = cfg_q.width16 ? 17'd15999 : 17'd1599;
            endcase
         end
      end
      if (bcdMode && cfg_q.dispUnit < UNIT_RPM_MIN) begin
         unit = (cfg_q.fmt < 3'd3) ? U_PCT : U_HZ;
         mult = (cfg_q.fmt == 3'd0 || cfg_q.fmt == 3'd3) ? 7'd100
            : (cfg_q.fmt == 3'd1 || cfg_q.fmt == 3'd4) ? 7'd10 : 7'd1;
      end
      if (cfg_q.fmt == FMT_BCD5 && cfg_q.card16 && !bcdMode) begin
         unit = U_HZ;
      end
      if (mag > limit) begin
         ok = 1'b0;
      end
      scaled = 32'(mag) * 32'(mult);
      if (neg) begin
         scaled = -scaled;
      end
   end

   // ----------------------------------------
   // reference capture and bus slave
   // ----------------------------------------
   always_comb begin
      cfg_d = cfg_q;
      ref_d = ref_q;
      valid_d = valid_q;
      rangeErr_d = rangeErr_q;
      fmtRej_d = fmtRej_q;
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((read || write) && wait_q) begin
         wait_d = 1'b0;
         if (read) begin
            unique case (address)
               OFF_CTRL: rdata_d = 32'({cfg_q.width16, cfg_q.card16, cfg_q.fmt});
               OFF_UNIT: rdata_d = {16'h0000, cfg_q.dispUnit};
               OFF_STAT: rdata_d = 32'({ref_q.decimals, ref_q.unit, ref_q.full, fmtRej_q, rangeErr_q, valid_q});
               OFF_REF: rdata_d = ref_q.value;
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
      // write lands when waitrequest is low
      if (write && !wait_q) begin
         if (address == OFF_CTRL && byteenable[0]) begin
            cfg_d.fmt = writedata[CTRL_FMT_LSB +: 3];
            cfg_d.card16 = writedata[CTRL_CARD16_BIT];
            cfg_d.width16 = writedata[CTRL_WIDTH16_BIT];
         end else if (address == OFF_UNIT) begin
            if (byteenable[0]) cfg_d.dispUnit[7:0] = writedata[7:0];
            if (byteenable[1]) cfg_d.dispUnit[15:8] = writedata[15:8];
         end else if (address == OFF_STAT && byteenable[0]) begin
            // write one clears error flags
            if (writedata[STAT_RANGE_BIT]) rangeErr_d = 1'b0;
            if (writedata[STAT_FMTREJ_BIT]) fmtRej_d = 1'b0;
         end
      end
      if (capture) begin
         if (ok) begin
            ref_d = '{value: scaled, unit: unit, decimals: decs, full: full};
            valid_d = 1'b1;
         end else if (!cfg_q.card16 && cfg_q.fmt == FMT_BCD5 && cfg_q.dispUnit < UNIT_RPM_MIN) begin
            fmtRej_d = 1'b1;
         end else begin
            rangeErr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cfg_q <= '{fmt: FMT_RST, card16: 1'b0, width16: 1'b0, dispUnit: UNIT_RST};
         ref_q <= '{value: 32'sh0, unit: U_HZ, decimals: 2'd0, full: 1'b0};
         valid_q <= 1'b0;
         rangeErr_q <= 1'b0;
         fmtRej_q <= 1'b0;
         strobePrev_q <= 1'b0;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         cfg_q <= cfg_d;
         ref_q <= ref_d;
         valid_q <= valid_d;
         rangeErr_q <= rangeErr_d;
         fmtRej_q <= fmtRej_d;
         strobePrev_q <= refStrobe;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign refOut = ref_q;
   assign refValid = valid_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_hold;
      !capture |=> $stable(ref_q);
   endproperty
   a_hold: assert property (p_hold) else $error("reference changed without strobe");

   property p_reject;
      capture && !ok |=> $stable(ref_q) && (rangeErr_q || fmtRej_q);
   endproperty
   a_reject: assert property (p_reject) else $error("bad value not rejected");

   property p_no6;
      capture && !cfg_q.card16 && cfg_q.fmt == FMT_BCD5 && cfg_q.dispUnit < UNIT_RPM_MIN |=> fmtRej_q;
   endproperty
   a_no6: assert property (p_no6) else $error("code 6 accepted on eight-bit card");

   property p_full16;
      capture && cfg_q.card16 && cfg_q.width16 && cfg_q.fmt == FMT_BIN && cfg_q.dispUnit < UNIT_RPM_MIN
         && &refData && !refSign |=> ref_q.full && ref_q.value == 32'sd30000;
   endproperty
   a_full16: assert property (p_full16) else $error("all ones not full speed");

   property p_pos6;
      capture && ok && cfg_q.card16 && cfg_q.fmt == FMT_BCD5 && cfg_q.dispUnit < UNIT_RPM_MIN
         |=> ref_q.value >= 0 && ref_q.value <= 32'sd39998;
   endproperty
   a_pos6: assert property (p_pos6) else $error("code 6 value out of span");

   property p_bin8;
      capture && !cfg_q.card16 && cfg_q.fmt == FMT_BIN && cfg_q.dispUnit < UNIT_RPM_MIN
         && refData[7:0] == 8'ha5 && refSign |=> ref_q.value == -32'sd165;
   endproperty
   a_bin8: assert property (p_bin8) else $error("eight-bit binary wrong");

   property p_bcd8;
      capture && !cfg_q.card16 && cfg_q.fmt == 3'h0 && cfg_q.dispUnit < UNIT_RPM_MIN
         && refData[7:0] == 8'h23 && !refSign |=> ref_q.value == 32'sd2300 && ref_q.unit == U_PCT;
   endproperty
   a_bcd8: assert property (p_bcd8) else $error("eight-bit bcd wrong");

   property p_rpm;
      capture && cfg_q.card16 && cfg_q.width16 && cfg_q.dispUnit == 16'd4 && refData == 16'h1234 && !refSign
         |=> ref_q.value == 32'sd1234 && ref_q.unit == U_RPM;
   endproperty
   a_rpm: assert property (p_rpm) else $error("rpm decode wrong");

   property p_wait;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer timing wrong");
endmodule // pdrd_decoder

// ===== testbench/pdrd_ctrl_model.sv
// external controller model driving the reference terminals
`timescale 1ns/1ps
module pdrd_ctrl_model (
   input wire logic sys_clk,
   output logic [15:0] refData,
   output logic refSign,
   output logic refStrobe
);
   // ----------------------------------------
   // terminal drive
   // ----------------------------------------
   initial begin
      refData = 16'h0000;
      refSign = 1'b0;
      refStrobe = 1'b0;
   end

   task automatic send(input logic [15:0] d, input logic s);
      @(posedge sys_clk);
      refData <= d;
      refSign <= s;
      refStrobe <= 1'b0;
      @(posedge sys_clk);
      refStrobe <= 1'b1;
      @(posedge sys_clk);
      refStrobe <= 1'b0;
      // lines move on the same edge that drops strobe
      refData <= ~d;
      refSign <= ~s;
   endtask
endmodule // pdrd_ctrl_model

// ===== testbench/pdrd_decoder_tb.sv
// self-checking bench of the parallel reference decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nFail++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module pdrd_decoder_tb import pdrd_pkg::*;;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sys_clk;
   logic rstn;
   logic [3:0] address;
   logic read;
   logic write;
   logic [3:0] byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic [15:0] refData;
   logic refSign;
   logic refStrobe;
   pdrd_ref_t refOut;
   logic refValid;
   logic [31:0] rd;
   int nFail = 0;
   int numChecks = 0;
   int cyc = 0;

   pdrd_decoder DUT (.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .refData(refData), .refSign(refSign), .refStrobe(refStrobe), .refOut(refOut), .refValid(refValid));
   pdrd_ctrl_model M (.sys_clk(sys_clk), .refData(refData), .refSign(refSign), .refStrobe(refStrobe));

   // ----------------------------------------
   // clock, timeout, closing
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, nFail);
      if (nFail == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         nFail++;
         endSim();
      end
   end

   // ----------------------------------------
   // bus and decode tasks
   // ----------------------------------------
   task automatic busAcc(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= d;
      @(posedge sys_clk);
      while (waitrequest !== 1'b0) @(posedge sys_clk);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic dec(input logic [4:0] ctrl, input logic [15:0] unit, input logic [15:0] d, input logic s,
      input logic signed [31:0] ev, input pdrd_unit_t eu);
      busAcc(1'b1, OFF_CTRL, {27'h0000000, ctrl});
      busAcc(1'b1, OFF_UNIT, {16'h0000, unit});
      M.send(d, s);
      repeat (2) @(posedge sys_clk);
      `CHK("value", ev, refOut.value)
      `CHK("unit", eu, refOut.unit)
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'hf;
      writedata = 32'h00000000;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      busAcc(1'b0, OFF_CTRL, 32'h00000000);
      `CHK("ctrl reset", 32'h00000000, rd)
      busAcc(1'b0, OFF_UNIT, 32'h00000000);
      `CHK("unit reset", 32'h00000000, rd)
      busAcc(1'b0, 4'h2, 32'h00000000);
      `CHK("unmapped", 32'h00000000, rd)
      `CHK("valid idle", 1'b0, refValid)
      dec(5'h07, 16'h0000, 16'h00a5, 1'b1, -32'sd165, U_BIN);
      `CHK("valid", 1'b1, refValid)
      busAcc(1'b0, OFF_REF, 32'h00000000);
      `CHK("ref reg", 32'hffffff5b, rd)
      dec(5'h07, 16'h0000, 16'h00ff, 1'b0, 32'sd255, U_BIN);
      `CHK("full", 1'b1, refOut.full)
      dec(5'h00, 16'h0000, 16'h0023, 1'b0, 32'sd2300, U_PCT);
      dec(5'h03, 16'h0001, 16'h0015, 1'b1, -32'sd1500, U_HZ);
      dec(5'h06, 16'h0000, 16'h0011, 1'b0, -32'sd1500, U_HZ);
      busAcc(1'b0, OFF_STAT, 32'h00000000);
      `CHK("format reject", 1'b1, rd[STAT_FMTREJ_BIT])
      dec(5'h0e, 16'h0000, 16'hffff, 1'b1, 32'sd39998, U_HZ);
      dec(5'h1c, 16'h0000, 16'h1234, 1'b0, 32'sd12340, U_HZ);
      dec(5'h0f, 16'h0000, 16'h0fff, 1'b1, -32'sd4095, U_BIN);
      dec(5'h1f, 16'h0000, 16'hffff, 1'b0, 32'sd30000, U_BIN);
      `CHK("full16", 1'b1, refOut.full)
      dec(5'h18, 16'd12000, 16'h1234, 1'b0, 32'sd1234, U_USER);
      `CHK("decimals", 2'd1, refOut.decimals)
      dec(5'h1f, 16'h0000, 16'h7530, 1'b1, -32'sd30000, U_BIN);
      dec(5'h1f, 16'h0000, 16'h80e9, 1'b0, -32'sd30000, U_BIN);
      busAcc(1'b0, OFF_STAT, 32'h00000000);
      `CHK("range flag", 1'b1, rd[STAT_RANGE_BIT])
      busAcc(1'b1, OFF_STAT, 32'h00000006);
      busAcc(1'b0, OFF_STAT, 32'h00000000);
      `CHK("flags cleared", 2'b00, rd[2:1])
      dec(5'h1f, 16'd4, 16'h1234, 1'b0, 32'sd1234, U_RPM);
      repeat (3) @(posedge sys_clk);
      `CHK("ref held", 32'sd1234, refOut.value)
      endSim();
   end
endmodule // pdrd_decoder_tb
